// ### pvm_defines.vh
// constants for the vendor mode register bank
// included by pvm_regs.v; definitions only
`ifndef PVM_DEFINES_VH
`define PVM_DEFINES_VH

`define PVM_ADDR_MODE_CTRL 5'h11
`define PVM_ADDR_SPECIAL 5'h12
`define PVM_ADDR_SYM_ERR 5'h1a
`define PVM_ADDR_SPECIAL_CTRL 5'h1b

`define PVM_BIT_INT_STYLE 6
`define PVM_BIT_ADDR_BYPASS 3
`define PVM_BIT_FORCE_LINK 2
`define PVM_BIT_ENERGY 1
`define PVM_BIT_PORT_SEL 14
`define PVM_BIT_XOVER_SRC 15
`define PVM_BIT_AUTO_XOVER 14
`define PVM_BIT_PAIR_SWAP 13
`define PVM_BIT_HB_OFF 11
`define PVM_BIT_POLARITY 4
`define PVM_MODE_HI 7
`define PVM_MODE_LO 5
`define PVM_STN_HI 4
`define PVM_STN_LO 0
`define PVM_STRAP_SETTLE 2'h2

`define PVM_ENERGY_RESET 1'h1
`define PVM_CNT_RESET 16'h0000
`define PVM_ENERGY_TIMEOUT_MS 256
`define PVM_CLOCK_KHZ 50000

`endif

// ### pvm_regs.v
// vendor mode/status register bank of a 10/100 transceiver
// assumes a management frame decoder on clock_i giving one-cycle read/write strobes
`timescale 1ns/1ps
`default_nettype none
`include "pvm_defines.vh"
module pvm_regs #(
    parameter ENERGY_TIMEOUT_CYCLES = `PVM_ENERGY_TIMEOUT_MS * `PVM_CLOCK_KHZ
) (
    input wire clock_i,
    input wire rst_i,
    input wire soft_rst_i,
    input wire [4:0] mgmt_phy_addr_i,
    input wire [4:0] mgmt_reg_addr_i,
    input wire mgmt_wr_i,
    input wire mgmt_rd_i,
    input wire [15:0] mgmt_wdata_i,
    output reg [15:0] mgmt_rdata_o,
    output reg mgmt_rvalid_o,
    input wire strap_port_select_i,
    input wire [2:0] strap_mode_i,
    input wire [4:0] strap_station_address_i,
    input wire energy_seen_i,
    input wire rx_symbol_error_i,
    input wire rx_packet_end_i,
    input wire speed_10_i,
    input wire polarity_reversed_i,
    input wire crossover_enable_pin_i,
    input wire manual_pair_swap_pin_i,
    output reg interrupt_style_select_o,
    output reg force_link_o,
    output reg link_100tx_forced_o,
    output reg mac_port_select_o,
    output reg [2:0] operating_mode_o,
    output reg [4:0] station_address_o,
    output reg auto_crossover_o,
    output reg pair_swap_o,
    output reg heartbeat_test_on_o
);

    localparam CNT_W = 32;
    localparam [CNT_W-1:0] ENERGY_LIMIT = ENERGY_TIMEOUT_CYCLES - 1;

    // positions in the synchroniser vector
    localparam SYNC_W = 17;
    localparam IX_ENERGY = 0;
    localparam IX_SYM_ERR = 1;
    localparam IX_PKT_END = 2;
    localparam IX_SPEED = 3;
    localparam IX_POL = 4;
    localparam IX_XEN = 5;
    localparam IX_XSEL = 6;
    localparam IX_SOFT = 7;
    localparam IX_STN_LO = 8;
    localparam IX_STN_HI = 12;
    localparam IX_MODE_LO = 13;
    localparam IX_MODE_HI = 15;
    localparam IX_PORT = 16;

    // every pin-side input, straps too, passes two flops first
    wire [SYNC_W-1:0] sync_raw = {
        strap_port_select_i,
        strap_mode_i,
        strap_station_address_i,
        soft_rst_i,
        manual_pair_swap_pin_i,
        crossover_enable_pin_i,
        polarity_reversed_i,
        speed_10_i,
        rx_packet_end_i,
        rx_symbol_error_i,
        energy_seen_i
    };
    wire [SYNC_W-1:0] sync_out;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
            reg [1:0] stage_q;
            always @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    stage_q <= 2'h0;
                end else begin
                    stage_q <= {stage_q[0], sync_raw[gi]};
                end
            end
            assign sync_out[gi] = stage_q[1];
        end
    endgenerate

    wire soft_rst = sync_out[IX_SOFT];
    wire energy_now = sync_out[IX_ENERGY];
    wire sym_err = sync_out[IX_SYM_ERR];
    wire pkt_end = sync_out[IX_PKT_END];
    wire speed_10 = sync_out[IX_SPEED];
    wire pol_now = sync_out[IX_POL];
    wire xen_now = sync_out[IX_XEN];
    wire xsel_now = sync_out[IX_XSEL];
    wire [4:0] strap_station = sync_out[IX_STN_HI:IX_STN_LO];
    wire [2:0] strap_mode = sync_out[IX_MODE_HI:IX_MODE_LO];
    wire strap_port = sync_out[IX_PORT];

    // straps are caught once the synchronisers hold them, not before
    reg strap_taken_q;
    reg [1:0] strap_age_q;

    // register fields
    reg int_style_q;
    reg addr_bypass_q;
    reg force_link_q;
    reg energy_q;
    reg port_sel_q;
    reg [2:0] mode_q;
    reg [4:0] station_addr_q;
    reg [15:0] sym_cnt_q;
    reg pkt_err_seen_q;
    reg xover_src_q;
    reg auto_xover_q;
    reg pair_swap_q;
    reg hb_off_q;
    reg [CNT_W-1:0] quiet_cnt_q;

    wire addr_match = (mgmt_phy_addr_i == station_addr_q) || addr_bypass_q;
    wire wr_ok = mgmt_wr_i && addr_match && !soft_rst;
    wire wr_mode = wr_ok && (mgmt_reg_addr_i == `PVM_ADDR_MODE_CTRL);
    wire wr_special = wr_ok && (mgmt_reg_addr_i == `PVM_ADDR_SPECIAL);
    wire wr_sctrl = wr_ok && (mgmt_reg_addr_i == `PVM_ADDR_SPECIAL_CTRL);

    // hard reset only: immune fields and straps
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            strap_taken_q <= 1'h0;
            strap_age_q <= 2'h0;
            port_sel_q <= 1'h0;
            mode_q <= 3'h0;
            station_addr_q <= 5'h00;
            hb_off_q <= 1'h0;
        end else begin
            if (!strap_taken_q) begin
                if (strap_age_q == `PVM_STRAP_SETTLE) begin
                    strap_taken_q <= 1'h1;
                    port_sel_q <= strap_port;
                    mode_q <= strap_mode;
                    station_addr_q <= strap_station;
                end else begin
                    strap_age_q <= strap_age_q + 2'h1;
                end
            end else if (wr_special) begin
                // soft reset leaves these alone
                port_sel_q <= mgmt_wdata_i[`PVM_BIT_PORT_SEL];
                mode_q <= mgmt_wdata_i[`PVM_MODE_HI:`PVM_MODE_LO];
                station_addr_q <= mgmt_wdata_i[`PVM_STN_HI:`PVM_STN_LO];
            end
            if (strap_taken_q && wr_sctrl) begin
                hb_off_q <= mgmt_wdata_i[`PVM_BIT_HB_OFF];
            end
        end
    end

    // energy timer runs through soft reset
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            energy_q <= `PVM_ENERGY_RESET;
            quiet_cnt_q <= {CNT_W{1'b0}};
        end else begin
            if (energy_now) begin
                quiet_cnt_q <= {CNT_W{1'b0}};
                energy_q <= 1'h1;
            end else if (quiet_cnt_q >= ENERGY_LIMIT) begin
                energy_q <= 1'h0;
            end else begin
                quiet_cnt_q <= quiet_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ordinary fields: hard or soft reset
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            int_style_q <= 1'h0;
            addr_bypass_q <= 1'h0;
            force_link_q <= 1'h0;
            xover_src_q <= 1'h0;
            auto_xover_q <= 1'h0;
            pair_swap_q <= 1'h0;
        end else if (soft_rst) begin
            int_style_q <= 1'h0;
            addr_bypass_q <= 1'h0;
            force_link_q <= 1'h0;
            xover_src_q <= 1'h0;
            auto_xover_q <= 1'h0;
            pair_swap_q <= 1'h0;
        end else begin
            if (wr_mode) begin
                int_style_q <= mgmt_wdata_i[`PVM_BIT_INT_STYLE];
                addr_bypass_q <= mgmt_wdata_i[`PVM_BIT_ADDR_BYPASS];
                force_link_q <= mgmt_wdata_i[`PVM_BIT_FORCE_LINK];
            end
            if (wr_sctrl) begin
                xover_src_q <= mgmt_wdata_i[`PVM_BIT_XOVER_SRC];
                auto_xover_q <= mgmt_wdata_i[`PVM_BIT_AUTO_XOVER];
                pair_swap_q <= mgmt_wdata_i[`PVM_BIT_PAIR_SWAP];
            end
        end
    end

    // bad symbol tally: hard or soft reset clears it, reads never do
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sym_cnt_q <= `PVM_CNT_RESET;
            pkt_err_seen_q <= 1'h0;
        end else if (soft_rst) begin
            sym_cnt_q <= `PVM_CNT_RESET;
            pkt_err_seen_q <= 1'h0;
        end else begin
            // one count per packet; errors at 10 Mb/s are neither counted nor marked
            if (sym_err && !speed_10 && !pkt_err_seen_q) begin
                sym_cnt_q <= sym_cnt_q + 16'h0001;
            end
            if (pkt_end) begin
                pkt_err_seen_q <= 1'h0;
            end else if (sym_err && !speed_10) begin
                pkt_err_seen_q <= 1'h1;
            end
        end
    end

    // read mux; reserved bits read zero, tally untouched by reads
    reg [15:0] rdata_d;
    always @* begin
        rdata_d = 16'h0000;
        case (mgmt_reg_addr_i)
            `PVM_ADDR_MODE_CTRL: begin
                rdata_d[`PVM_BIT_INT_STYLE] = int_style_q;
                rdata_d[`PVM_BIT_ADDR_BYPASS] = addr_bypass_q;
                rdata_d[`PVM_BIT_FORCE_LINK] = force_link_q;
                rdata_d[`PVM_BIT_ENERGY] = energy_q;
            end
            `PVM_ADDR_SPECIAL: begin
                rdata_d[`PVM_BIT_PORT_SEL] = port_sel_q;
                rdata_d[`PVM_MODE_HI:`PVM_MODE_LO] = mode_q;
                rdata_d[`PVM_STN_HI:`PVM_STN_LO] = station_addr_q;
            end
            `PVM_ADDR_SYM_ERR: begin
                rdata_d = sym_cnt_q;
            end
            `PVM_ADDR_SPECIAL_CTRL: begin
                rdata_d[`PVM_BIT_XOVER_SRC] = xover_src_q;
                rdata_d[`PVM_BIT_AUTO_XOVER] = auto_xover_q;
                rdata_d[`PVM_BIT_PAIR_SWAP] = pair_swap_q;
                rdata_d[`PVM_BIT_HB_OFF] = hb_off_q;
                rdata_d[`PVM_BIT_POLARITY] = pol_now;
            end
            default: begin
                rdata_d = 16'h0000;
            end
        endcase
    end

    // crossover source: pins or register bits
    wire auto_x_d = xover_src_q ? auto_xover_q : xen_now;
    wire swap_d = xover_src_q ? (!auto_xover_q && pair_swap_q) : xsel_now;

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mgmt_rdata_o <= 16'h0000;
            mgmt_rvalid_o <= 1'h0;
            interrupt_style_select_o <= 1'h0;
            force_link_o <= 1'h0;
            link_100tx_forced_o <= 1'h0;
            mac_port_select_o <= 1'h0;
            operating_mode_o <= 3'h0;
            station_address_o <= 5'h00;
            auto_crossover_o <= 1'h0;
            pair_swap_o <= 1'h0;
            heartbeat_test_on_o <= 1'h1;
        end else begin
            mgmt_rvalid_o <= mgmt_rd_i && (mgmt_phy_addr_i == station_addr_q);
            mgmt_rdata_o <= rdata_d;
            interrupt_style_select_o <= int_style_q;
            force_link_o <= force_link_q;
            link_100tx_forced_o <= force_link_q;
            mac_port_select_o <= port_sel_q;
            operating_mode_o <= mode_q;
            station_address_o <= station_addr_q;
            auto_crossover_o <= auto_x_d;
            pair_swap_o <= swap_d;
            heartbeat_test_on_o <= !hb_off_q;
        end
    end

endmodule // pvm_regs
`default_nettype wire

// ### pvm_checker.sv
// port assertions for the vendor mode register bank
// bound to pvm_regs in the testbench top; one clock, async reset
`timescale 1ns/1ps
`default_nettype none
module pvm_checker (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    input wire logic [4:0] mgmt_phy_addr_i,
    input wire logic [4:0] mgmt_reg_addr_i,
    input wire logic mgmt_wr_i,
    input wire logic mgmt_rd_i,
    input wire logic [15:0] mgmt_wdata_i,
    input wire logic mgmt_rvalid_o,
    input wire logic interrupt_style_select_o,
    input wire logic force_link_o,
    input wire logic link_100tx_forced_o,
    input wire logic [2:0] operating_mode_o,
    input wire logic [4:0] station_address_o,
    input wire logic heartbeat_test_on_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic [15:0] wd_q, wd2_q;
    wire hit = mgmt_phy_addr_i == station_address_o;
    wire wr_on = mgmt_wr_i && hit;
    always @(posedge clock_i) {wd2_q, wd_q} <= {wd_q, mgmt_wdata_i};
    rvalid_a: assert property (mgmt_rd_i && hit |=> mgmt_rvalid_o)
        else $error("addressed read not answered");
    no_rvalid_a: assert property (!(mgmt_rd_i && hit) |=> !mgmt_rvalid_o)
        else $error("answer without addressed read");
    style_wr_a: assert property ((!soft_rst_i)[*4] ##0 wr_on && mgmt_reg_addr_i == 5'h11
        |-> ##2 interrupt_style_select_o == wd2_q[6]) else $error("style bit not written");
    force_wr_a: assert property ((!soft_rst_i)[*4] ##0 wr_on && mgmt_reg_addr_i == 5'h11
        |-> ##2 force_link_o == wd2_q[2]) else $error("forced link not written");
    link_tie_a: assert property (force_link_o == link_100tx_forced_o)
        else $error("forced link report differs");
    hb_wr_a: assert property ((!soft_rst_i)[*4] ##0 wr_on && mgmt_reg_addr_i == 5'h1b
        |-> ##2 heartbeat_test_on_o == !wd2_q[11]) else $error("heartbeat bit wrong");
    addr_wr_a: assert property ((!soft_rst_i)[*4] ##0 wr_on && mgmt_reg_addr_i == 5'h12
        |-> ##2 station_address_o == wd2_q[4:0] && operating_mode_o == wd2_q[7:5])
        else $error("mode or address not written");
    hard_rst_a: assert property ($fell(rst_i) |-> !interrupt_style_select_o
        && heartbeat_test_on_o) else $error("wrong state after reset");
endmodule // pvm_checker
`default_nettype wire

// ### pvm_host.sv
// management host model issuing one-cycle read and write strobes
// runs on the block clock; released lines show the inverse value
`timescale 1ns/1ps
`default_nettype none
module pvm_host (
    input wire logic clock_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output logic [4:0] phy_addr_o,
    output logic [4:0] reg_addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] wdata_o
);
    initial {phy_addr_o, reg_addr_o, wr_o, rd_o, wdata_o} = '0;
    // callers keep reserved bits zero and port select at its strap value
    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        @(posedge clock_i);
        {wr_o, phy_addr_o, reg_addr_o, wdata_o} <= {1'b1, pa, ra, d};
        @(posedge clock_i);
        {wr_o, phy_addr_o, reg_addr_o, wdata_o} <= {1'b0, ~pa, ~ra, ~d};
    endtask
    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, output logic ok,
        output logic [15:0] d);
        @(posedge clock_i);
        {rd_o, phy_addr_o, reg_addr_o} <= {1'b1, pa, ra};
        @(posedge clock_i);
        {rd_o, phy_addr_o, reg_addr_o} <= {1'b0, ~pa, ~ra};
        // the answer stands for one cycle after this edge; look once it settles
        #1;
        ok = rvalid_i;
        d = rdata_i;
    endtask
endmodule // pvm_host
`default_nettype wire

// ### pvm_regs_tb.sv
// self-checking bench for the vendor mode register bank
// host model makes accesses; line status and straps driven here
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module pvm_regs_tb;
    logic clock_i = 0, rst_i = 1, soft_rst_i = 0, ok;
    logic en = 1, err = 0, pend = 0, s10 = 0, pol = 0, xen = 0, xsw = 0, ps_s = 1;
    logic [2:0] md_s = 3'h5;
    logic [4:0] sa_s = 5'h0a;
    logic [15:0] d;
    wire [4:0] pa, ra, sa;
    wire [2:0] mode;
    wire [15:0] wd, rdat;
    wire wr, rd, rv, style, frc, lnk, mps, ax, psw, hb;
    int err_count = 0, n_compared = 0;
    initial forever #10 clock_i = ~clock_i;
    pvm_host i_host (.clock_i(clock_i), .rdata_i(rdat), .rvalid_i(rv), .phy_addr_o(pa),
        .reg_addr_o(ra), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
    pvm_regs #(.ENERGY_TIMEOUT_CYCLES(20)) i_dut (.clock_i(clock_i), .rst_i(rst_i),
        .soft_rst_i(soft_rst_i), .mgmt_phy_addr_i(pa), .mgmt_reg_addr_i(ra), .mgmt_wr_i(wr),
        .mgmt_rd_i(rd), .mgmt_wdata_i(wd), .mgmt_rdata_o(rdat), .mgmt_rvalid_o(rv),
        .strap_port_select_i(ps_s), .strap_mode_i(md_s), .strap_station_address_i(sa_s),
        .energy_seen_i(en), .rx_symbol_error_i(err), .rx_packet_end_i(pend),
        .speed_10_i(s10), .polarity_reversed_i(pol), .crossover_enable_pin_i(xen),
        .manual_pair_swap_pin_i(xsw), .interrupt_style_select_o(style), .force_link_o(frc),
        .link_100tx_forced_o(lnk), .mac_port_select_o(mps), .operating_mode_o(mode),
        .station_address_o(sa), .auto_crossover_o(ax), .pair_swap_o(psw),
        .heartbeat_test_on_o(hb));
    task cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // a missing answer cannot be recovered, so the run ends there
    task rdc(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e);
        i_host.rd(p, r, ok, d);
        `CHK({ok, d}, {1'b1, e})
        if (!ok) close_out();
    endtask
    task sym(input logic e, input logic p);
        @(posedge clock_i) {err, pend} <= {e, p};
        @(posedge clock_i) {err, pend} <= 2'b00;
        cyc(3);
    endtask
    task t_reset;
        rdc(5'h0a, 5'h11, 16'h0002);
        rdc(5'h0a, 5'h12, 16'h40aa);
        rdc(5'h0a, 5'h1a, 16'h0000);
        rdc(5'h0a, 5'h1b, 16'h0000);
        `CHK({style, hb, mps, mode, sa, ax, psw}, 13'h0ea8)
        $display("reset test done");
    endtask
    task t_mode;
        i_host.wr(5'h0a, 5'h11, 16'h004c);
        cyc(2);
        `CHK({style, frc, lnk}, 3'h7)
        rdc(5'h0a, 5'h11, 16'h004e);
        i_host.wr(5'h1f, 5'h11, 16'h0000);
        cyc(2);
        `CHK({style, frc}, 2'b00)
        i_host.wr(5'h1f, 5'h11, 16'h0040);
        cyc(2);
        `CHK(style, 1'b0)
        i_host.rd(5'h1f, 5'h11, ok, d);
        `CHK(ok, 1'b0)
        $display("mode test done");
    endtask
    task t_special;
        i_host.wr(5'h0a, 5'h12, 16'h4043);
        cyc(2);
        `CHK({mps, mode, sa}, 9'h143)
        rdc(5'h03, 5'h12, 16'h4043);
        $display("special test done");
    endtask
    task t_xover;
        @(posedge clock_i) {xsw, pol} <= 2'b11;
        cyc(4);
        `CHK({ax, psw}, 2'b01)
        i_host.wr(5'h03, 5'h1b, 16'h8000);
        cyc(2);
        `CHK({ax, psw, hb}, 3'b001)
        i_host.wr(5'h03, 5'h1b, 16'ha800);
        cyc(2);
        `CHK({ax, psw, hb}, 3'b010)
        i_host.wr(5'h03, 5'h1b, 16'hc800);
        cyc(2);
        `CHK({ax, hb}, 2'b10)
        rdc(5'h03, 5'h1b, 16'hc810);
        $display("crossover test done");
    endtask
    task t_tally;
        sym(1, 0);
        sym(1, 0);
        sym(0, 1);
        sym(1, 0);
        sym(0, 1);
        @(posedge clock_i) s10 <= 1'b1;
        cyc(4);
        sym(1, 0);
        sym(0, 1);
        @(posedge clock_i) s10 <= 1'b0;
        rdc(5'h03, 5'h1a, 16'h0002);
        rdc(5'h03, 5'h1a, 16'h0002);
        $display("tally test done");
    endtask
    task t_soft;
        i_host.wr(5'h03, 5'h11, 16'h0040);
        @(posedge clock_i) soft_rst_i <= 1'b1;
        cyc(3);
        soft_rst_i <= 1'b0;
        cyc(4);
        `CHK({style, ax, mps, mode, sa, hb}, 12'h286)
        rdc(5'h03, 5'h1a, 16'h0000);
        rdc(5'h03, 5'h11, 16'h0002);
        en <= 1'b0;
        cyc(30);
        rdc(5'h03, 5'h11, 16'h0000);
        en <= 1'b1;
        cyc(4);
        rdc(5'h03, 5'h11, 16'h0002);
        $display("soft reset test done");
    endtask
    initial begin
        cyc(3);
        rst_i <= 1'b0;
        cyc(4);
        t_reset;
        t_mode;
        t_special;
        t_xover;
        t_tally;
        t_soft;
        close_out();
    end
endmodule // pvm_regs_tb
bind pvm_regs pvm_checker i_chk (.clock_i(clock_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .mgmt_phy_addr_i(mgmt_phy_addr_i), .mgmt_reg_addr_i(mgmt_reg_addr_i),
    .mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i), .mgmt_wdata_i(mgmt_wdata_i),
    .mgmt_rvalid_o(mgmt_rvalid_o), .interrupt_style_select_o(interrupt_style_select_o),
    .force_link_o(force_link_o), .link_100tx_forced_o(link_100tx_forced_o),
    .operating_mode_o(operating_mode_o), .station_address_o(station_address_o),
    .heartbeat_test_on_o(heartbeat_test_on_o));
`default_nettype wire
